// file: core/afe_pkg.sv
// Purpose: shared constants, types and decode for the afe control bank
// Assumes: six 16-bit registers, 3-bit address, LSB-first serial frame
// Notes:   reset values and field positions live here only
package afe_pkg;

  // ****************************************************************
  // widths and frame
  // ****************************************************************
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned FRAME_W  = ADDR_W + DATA_W;
  localparam logic [4:0]  FRAME_BITS = 5'h13;
  localparam logic [4:0]  READ_BITS  = 5'h10;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [2:0] ADDR_POWER_DOWN_CONTROL     = 3'h0;
  localparam logic [2:0] ADDR_RECEIVE_FILTER_CONTROL = 3'h1;
  localparam logic [2:0] ADDR_GAIN_AND_TUNE_CONTROL  = 3'h2;
  localparam logic [2:0] ADDR_RESERVED_CONFIG_A      = 3'h3;
  localparam logic [2:0] ADDR_RESERVED_CONFIG_B      = 3'h4;
  localparam logic [2:0] ADDR_DRIVER_AND_FILTER_CTRL = 3'h5;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned RX_OFF_DURING_TX_BIT        = 0;
  localparam int unsigned TX_OFF_DURING_RX_BIT        = 1;
  localparam int unsigned CONVERTER_OFF_DURING_RX_BIT = 2;
  localparam int unsigned FULL_CHIP_POWERDOWN_BIT     = 3;
  localparam int unsigned RX_LOWPASS_BYPASS_BIT       = 15;
  localparam int unsigned PREDRIVER_GAIN_LSB          = 2;
  localparam int unsigned PROCESS_TUNE_CONTINUOUS_BIT = 11;
  localparam int unsigned DRIVER_BYPASS_SELECT_LSB    = 1;
  localparam int unsigned TX_LOWPASS_BYPASS_BIT       = 4;
  localparam int unsigned RX_HIGHPASS_DISABLE_BIT     = 14;
  localparam logic [2:0]  GAIN_CODE_MIN_6DB           = 3'h7;
  localparam logic [1:0]  DRIVER_ACTIVE               = 2'h0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] RST_POWER_DOWN_CONTROL     = 16'h0003;
  localparam logic [15:0] RST_RECEIVE_FILTER_CONTROL = 16'h0008;
  localparam logic [15:0] RST_GAIN_AND_TUNE_CONTROL  = 16'h7800;
  localparam logic [15:0] RST_RESERVED_CONFIG_A      = 16'h7ace;
  localparam logic [15:0] RST_RESERVED_CONFIG_B      = 16'h0000;
  localparam logic [15:0] RST_DRIVER_AND_FILTER_CTRL = 16'hc800;
  localparam logic [NUM_REGS-1:0][15:0] RST_BANK = {
    RST_DRIVER_AND_FILTER_CTRL, RST_RESERVED_CONFIG_B,
    RST_RESERVED_CONFIG_A, RST_GAIN_AND_TUNE_CONTROL,
    RST_RECEIVE_FILTER_CONTROL, RST_POWER_DOWN_CONTROL};

  // ****************************************************************
  // decoded controls
  // ****************************************************************
  typedef struct packed {
    logic              rx_off;
    logic              tx_off;
    logic              dac_off;
    logic              chip_off;
    logic              rx_lpf_bypass;
    logic [2:0]        gain_code;
    logic signed [3:0] gain_db;
    logic              tune_run;
    logic              ld_enable;
    logic [1:0]        drv_sel;
    logic              tx_lpf_bypass;
    logic              rx_hpf_disable;
  } afe_ctl_s;

  function automatic afe_ctl_s afe_decode(
    input logic [NUM_REGS-1:0][15:0] bank,
    input logic                      tx_mode);
    afe_ctl_s   c;
    logic [2:0] g;
    g = bank[ADDR_GAIN_AND_TUNE_CONTROL][PREDRIVER_GAIN_LSB +: 3];
    c.chip_off = bank[ADDR_POWER_DOWN_CONTROL][FULL_CHIP_POWERDOWN_BIT];
    c.rx_off = c.chip_off |
      (bank[ADDR_POWER_DOWN_CONTROL][RX_OFF_DURING_TX_BIT] & tx_mode);
    c.tx_off = c.chip_off |
      (bank[ADDR_POWER_DOWN_CONTROL][TX_OFF_DURING_RX_BIT] & ~tx_mode);
    c.dac_off = c.chip_off |
      (bank[ADDR_POWER_DOWN_CONTROL][CONVERTER_OFF_DURING_RX_BIT]
       & ~tx_mode);
    c.rx_lpf_bypass =
      bank[ADDR_RECEIVE_FILTER_CONTROL][RX_LOWPASS_BYPASS_BIT];
    c.gain_code = g;
    c.gain_db = (g == GAIN_CODE_MIN_6DB) ? -4'sd6
                : 4'(signed'(4'sd3 - signed'({1'b0, g})));
    c.tune_run =
      bank[ADDR_GAIN_AND_TUNE_CONTROL][PROCESS_TUNE_CONTINUOUS_BIT];
    c.drv_sel =
      bank[ADDR_DRIVER_AND_FILTER_CTRL][DRIVER_BYPASS_SELECT_LSB +: 2];
    c.ld_enable = (c.drv_sel == DRIVER_ACTIVE);
    c.tx_lpf_bypass =
      bank[ADDR_DRIVER_AND_FILTER_CTRL][TX_LOWPASS_BYPASS_BIT];
    c.rx_hpf_disable =
      bank[ADDR_DRIVER_AND_FILTER_CTRL][RX_HIGHPASS_DISABLE_BIT];
    return c;
  endfunction : afe_decode

  localparam afe_ctl_s RST_CTL = afe_decode(RST_BANK, 1'b0);

endpackage : afe_pkg

// file: core/afe_link_if.sv
// Purpose: carries committed serial words from link to core domain
// Assumes: hold words are stable whenever the toggle is seen to change
// Notes:   toggle is the only link signal the core synchronises
`timescale 1ns/1ns
`default_nettype none
interface afe_link_if;
  import afe_pkg::*;
  logic              commit_tgl;
  logic [ADDR_W-1:0] hold_addr;
  logic [DATA_W-1:0] hold_data;
  modport link (output commit_tgl, output hold_addr, output hold_data);
  modport core (input  commit_tgl, input  hold_addr, input  hold_data);
endinterface : afe_link_if
`default_nettype wire

// file: core/afe_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk_i
// Notes:   output follows once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module afe_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  if (W < 1) begin : g_chk
    $error("afe_sync3: W must be at least 1");
  end

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // ****************************************************************
  // agreement filter
  // ****************************************************************
  always_comb begin
    q_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & q_q);
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q  <= q_d;
    end
  end

  assign q_o = q_q;
endmodule : afe_sync3
`default_nettype wire

// file: core/afe_serial_link.sv
// Purpose: serial clock domain shifter for register write and read
// Assumes: serial clock runs only inside frames
// Notes:   write select high ends any read drive at once
`timescale 1ns/1ns
`default_nettype none
module afe_serial_link (
  input  wire logic   link_clk_i,
  input  wire logic   reset_i,
  input  wire logic   serial_write_select_i,
  input  wire logic   sdio_i,
  output logic        sdio_o,
  output logic        sdio_oe_n_o,
  afe_link_if.link    lk
);
  import afe_pkg::*;

  logic               mode_q;
  logic [4:0]         cnt_q,   cnt_d;
  logic [FRAME_W-1:0] shift_q, shift_d;
  logic [ADDR_W-1:0]  addr_q,  addr_d;
  logic [DATA_W-1:0]  data_q,  data_d;
  logic               tgl_q,   tgl_d;
  logic               wrote_q, wrote_d;
  logic [4:0]         rcnt_q,  rcnt_d;
  logic [DATA_W-1:0]  rsh_q,   rsh_d;
  logic               sdo_q,   sdo_d;
  logic               oe_n_q,  oe_n_d;
  logic               oe_clr;

  // ****************************************************************
  // frame next state
  // ****************************************************************
  always_comb begin
    logic [4:0] base;
    base    = mode_q ? cnt_q : 5'h00;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    addr_d  = addr_q;
    data_d  = data_q;
    tgl_d   = tgl_q;
    wrote_d = wrote_q;
    rcnt_d  = rcnt_q;
    rsh_d   = rsh_q;
    sdo_d   = sdo_q;
    oe_n_d  = 1'b1;
    if (serial_write_select_i) begin
      cnt_d  = base;
      rcnt_d = 5'h00;
      if (base < FRAME_BITS) begin
        shift_d = {sdio_i, shift_q[FRAME_W-1:1]};
        cnt_d   = base + 5'h01;
        wrote_d = 1'b0;
      end else if (base == FRAME_BITS) begin
        data_d  = shift_q[DATA_W-1:0];
        addr_d  = shift_q[FRAME_W-1:DATA_W];
        tgl_d   = ~tgl_q;
        wrote_d = 1'b1;
        cnt_d   = base + 5'h01;
      end
    end else if (mode_q) begin
      if (wrote_q) begin
        sdo_d   = data_q[0];
        rsh_d   = data_q >> 1;
        rcnt_d  = 5'h01;
        oe_n_d  = 1'b0;
        wrote_d = 1'b0;
      end
    end else if (rcnt_q != 5'h00 && rcnt_q < READ_BITS) begin
      sdo_d  = rsh_q[0];
      rsh_d  = rsh_q >> 1;
      rcnt_d = rcnt_q + 5'h01;
      oe_n_d = 1'b0;
    end else begin
      rcnt_d = 5'h00;
    end
  end

  // ****************************************************************
  // link registers, falling edge
  // ****************************************************************
  always_ff @(negedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q  <= 1'b0;
      cnt_q   <= 5'h00;
      shift_q <= '0;
      addr_q  <= '0;
      data_q  <= '0;
      tgl_q   <= 1'b0;
      wrote_q <= 1'b0;
      rcnt_q  <= 5'h00;
      rsh_q   <= '0;
      sdo_q   <= 1'b0;
    end else begin
      mode_q  <= serial_write_select_i;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
      tgl_q   <= tgl_d;
      wrote_q <= wrote_d;
      rcnt_q  <= rcnt_d;
      rsh_q   <= rsh_d;
      sdo_q   <= sdo_d;
    end
  end

  // ****************************************************************
  // drive enable, released by write select
  // ****************************************************************
  assign oe_clr = reset_i | serial_write_select_i;

  always_ff @(negedge link_clk_i or posedge oe_clr) begin
    if (oe_clr) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= oe_n_d;
    end
  end

  assign sdio_o        = sdo_q;
  assign sdio_oe_n_o   = oe_n_q;
  assign lk.commit_tgl = tgl_q;
  assign lk.hold_addr  = addr_q;
  assign lk.hold_data  = data_q;
endmodule : afe_serial_link
`default_nettype wire

// file: core/afe_control_register_bank.sv
// Purpose: control register bank of the analog front end
// Assumes: serial port on its own clock, transmit mode from a pin
// Notes:   all control outputs come from core clock flops
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - receiver off while transmitting when set
// - transmitter off while receiving when set
// - converter off while receiving when set
// - whole chip powered down when set
// - receive lowpass bypassed when set
// - three-bit predriver gain, 3 to -6 dB
// - tuning continuous when set, else reset only
// - line driver mode from two-bit select
// - transmit lowpass bypass allowed when set
// - receive highpass disabled when set
// - three-bit frame address picks register
// - bits LSB first on serial falling edge
// - extra clock moves holding buffer in
module afe_control_register_bank (
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  input  wire logic          serial_clk_i,
  input  wire logic          serial_write_select_i,
  input  wire logic          sdio_i,
  output logic               sdio_o,
  output logic               sdio_oe_n_o,
  input  wire logic          tx_mode_i,
  output logic               rx_section_off_o,
  output logic               tx_section_off_o,
  output logic               converter_off_o,
  output logic               full_chip_powerdown_o,
  output logic               rx_lowpass_bypass_o,
  output logic [2:0]         predriver_gain_o,
  output logic signed [3:0]  predriver_gain_db_o,
  output logic               process_tune_run_o,
  output logic               line_driver_enable_o,
  output logic [1:0]         driver_bypass_select_o,
  output logic               tx_lowpass_bypass_o,
  output logic               rx_highpass_disable_o
);
  import afe_pkg::*;

  afe_link_if lk ();

  logic                          tgl_sync;
  logic                          tx_mode;
  logic                          seen_q,  seen_d;
  logic [NUM_REGS-1:0][15:0]     bank_q,  bank_d;
  afe_ctl_s                      ctl_q,   ctl_d;

  // ****************************************************************
  // serial clock domain
  // ****************************************************************
  afe_serial_link u_link (
    .link_clk_i            (serial_clk_i),
    .reset_i               (reset_i),
    .serial_write_select_i (serial_write_select_i),
    .sdio_i                (sdio_i),
    .sdio_o                (sdio_o),
    .sdio_oe_n_o           (sdio_oe_n_o),
    .lk                    (lk.link)
  );

  // ****************************************************************
  // crossings into core clock
  // ****************************************************************
  afe_sync3 #(.W(1)) u_commit_sync (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .d_i     (lk.commit_tgl),
    .q_o     (tgl_sync)
  );

  afe_sync3 #(.W(1)) u_mode_sync (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .d_i     (tx_mode_i),
    .q_o     (tx_mode)
  );

  // ****************************************************************
  // register bank next state
  // ****************************************************************
  always_comb begin
    seen_d = tgl_sync;
    bank_d = bank_q;
    if ((tgl_sync != seen_q) && (lk.hold_addr < 3'(NUM_REGS))) begin
      bank_d[lk.hold_addr] = lk.hold_data;
    end
    ctl_d = afe_decode(bank_q, tx_mode);
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seen_q <= 1'b0;
      bank_q <= RST_BANK;
      ctl_q  <= RST_CTL;
    end else begin
      seen_q <= seen_d;
      bank_q <= bank_d;
      ctl_q  <= ctl_d;
    end
  end

  // ****************************************************************
  // control outputs
  // ****************************************************************
  assign rx_section_off_o       = ctl_q.rx_off;
  assign tx_section_off_o       = ctl_q.tx_off;
  assign converter_off_o        = ctl_q.dac_off;
  assign full_chip_powerdown_o  = ctl_q.chip_off;
  assign rx_lowpass_bypass_o    = ctl_q.rx_lpf_bypass;
  assign predriver_gain_o       = ctl_q.gain_code;
  assign predriver_gain_db_o    = ctl_q.gain_db;
  assign process_tune_run_o     = ctl_q.tune_run;
  assign line_driver_enable_o   = ctl_q.ld_enable;
  assign driver_bypass_select_o = ctl_q.drv_sel;
  assign tx_lowpass_bypass_o    = ctl_q.tx_lpf_bypass;
  assign rx_highpass_disable_o  = ctl_q.rx_hpf_disable;
endmodule : afe_control_register_bank
`default_nettype wire

// file: verif/afe_host_model.sv
// Purpose: baseband controller model driving the serial port
// Assumes: serial clock period 32 ns, still between frames
// Notes:   undriven line shows inverse of device data
`timescale 1ns/1ns
`default_nettype none
module afe_host_model (
  output logic      serial_clk_o,
  output logic      sel_o,
  output logic      line_o,
  input  wire logic dev_sdio_i,
  input  wire logic dev_oe_n_i
);
  // ****************************************************************
  // line and frames
  // ****************************************************************
  logic drv_q;
  logic bit_q;
  assign line_o = !dev_oe_n_i ? dev_sdio_i : (drv_q ? bit_q : ~dev_sdio_i);
  initial begin
    serial_clk_o = 1'b1;
    sel_o = 1'b0;
    drv_q = 1'b0;
    bit_q = 1'b0;
  end
  task automatic pulse();
    #15 serial_clk_o = 1'b0;
    #16 serial_clk_o = 1'b1;
    #1;
  endtask : pulse
  task automatic write_reg(input logic [2:0] a, input logic [15:0] d);
    logic [18:0] f;
    f = {a, d};
    sel_o = 1'b0;
    drv_q = 1'b0;
    pulse();
    sel_o = 1'b1;
    drv_q = 1'b1;
    for (int i = 0; i < 19; i++) begin
      bit_q = f[i];
      pulse();
    end
    drv_q = 1'b0;
    pulse();
  endtask : write_reg
  task automatic read_reg(output logic [15:0] d, output logic rel);
    sel_o = 1'b0;
    for (int i = 0; i < 16; i++) begin
      #15 serial_clk_o = 1'b0;
      #16 serial_clk_o = 1'b1;
      d[i] = line_o;
      #1;
    end
    pulse();
    rel = dev_oe_n_i;
  endtask : read_reg
endmodule : afe_host_model
`default_nettype wire

// file: verif/afe_control_register_bank_assertions.sv
// Purpose: port checks for the afe control bank
// Assumes: tx mode held eight core cycles has settled
// Notes:   bound to every bank instance
`timescale 1ns/1ns
`default_nettype none
module afe_control_register_bank_assertions (
  input wire logic              core_clk_i,
  input wire logic              reset_i,
  input wire logic              serial_write_select_i,
  input wire logic              sdio_oe_n_o,
  input wire logic              tx_mode_i,
  input wire logic              rx_section_off_o,
  input wire logic              tx_section_off_o,
  input wire logic              converter_off_o,
  input wire logic              full_chip_powerdown_o,
  input wire logic [2:0]        predriver_gain_o,
  input wire logic signed [3:0] predriver_gain_db_o,
  input wire logic              process_tune_run_o,
  input wire logic              line_driver_enable_o,
  input wire logic [1:0]        driver_bypass_select_o,
  input wire logic              rx_highpass_disable_o
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence tx_held; tx_mode_i [*8]; endsequence
  sequence rx_held; !tx_mode_i [*8]; endsequence
  chip_off_a: assert property (
    full_chip_powerdown_o |->
      rx_section_off_o && tx_section_off_o && converter_off_o)
    else $error("chip off left a section on");
  rx_off_a: assert property (
    rx_held |-> rx_section_off_o == full_chip_powerdown_o)
    else $error("receiver off in receive mode");
  tx_off_a: assert property (
    tx_held |-> tx_section_off_o == full_chip_powerdown_o)
    else $error("transmitter off in transmit mode");
  conv_on_a: assert property (
    tx_held |-> converter_off_o == full_chip_powerdown_o)
    else $error("converter off in transmit mode");
  gain_map_a: assert property (
    (predriver_gain_o == 3'h7) ? (predriver_gain_db_o == 4'sha)
      : (4'(predriver_gain_db_o) + 4'(predriver_gain_o) == 4'h3))
    else $error("gain code and dB disagree");
  ld_mode_a: assert property (
    line_driver_enable_o == (driver_bypass_select_o == 2'h0))
    else $error("line driver enable wrong");
  reset_dflt_a: assert property (
    $fell(reset_i) |-> process_tune_run_o && rx_highpass_disable_o
      && line_driver_enable_o && !full_chip_powerdown_o)
    else $error("reset defaults wrong");
  oe_release_a: assert property (
    serial_write_select_i |-> sdio_oe_n_o)
    else $error("data driven in write mode");
  read_drive_a: assert property (
    $fell(sdio_oe_n_o) |-> !serial_write_select_i)
    else $error("drive began outside read");
endmodule : afe_control_register_bank_assertions
bind afe_control_register_bank afe_control_register_bank_assertions u_chk (.*);
`default_nettype wire

// file: verif/afe_control_register_bank_test.sv
// Purpose: self-checking bench for the afe control bank
// Assumes: shadow copies of the bank predict all control outputs
// Notes:   serial traffic comes from the host model
`timescale 1ns/1ns
`default_nettype none
module afe_control_register_bank_test;
  import afe_pkg::*;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic core_clk_i, reset_i, tx_mode_i;
  wire  serial_clk_i, serial_write_select_i, sdio_i;
  logic sdio_o, sdio_oe_n_o, rx_section_off_o, tx_section_off_o;
  logic converter_off_o, full_chip_powerdown_o, rx_lowpass_bypass_o;
  logic process_tune_run_o, line_driver_enable_o, tx_lowpass_bypass_o;
  logic rx_highpass_disable_o;
  logic [2:0] predriver_gain_o;
  logic signed [3:0] predriver_gain_db_o;
  logic [1:0] driver_bypass_select_o;
  logic [15:0] r0, r1, r2, r5;
  logic [3:0] db_tab [8];
  logic [17:0] got;
  int bad_count = 0;
  int n_tests = 0;
  afe_control_register_bank DUT (.*);
  afe_host_model host (.serial_clk_o(serial_clk_i),
    .sel_o(serial_write_select_i), .line_o(sdio_i),
    .dev_sdio_i(sdio_o), .dev_oe_n_i(sdio_oe_n_o));
  assign got = {rx_section_off_o, tx_section_off_o, converter_off_o,
    full_chip_powerdown_o, rx_lowpass_bypass_o, predriver_gain_o,
    predriver_gain_db_o, process_tune_run_o, line_driver_enable_o,
    driver_bypass_select_o, tx_lowpass_bypass_o, rx_highpass_disable_o};
  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [17:0] exp_out();
    logic ch;
    ch = r0[3];
    return {ch | (r0[0] & tx_mode_i), ch | (r0[1] & ~tx_mode_i),
      ch | (r0[2] & ~tx_mode_i), ch, r1[15], r2[4:2], db_tab[r2[4:2]],
      r2[11], r5[2:1] == 2'h0, r5[2:1], r5[4], r5[14]};
  endfunction : exp_out
  task automatic chk_ctl(input logic [17:0] g, input logic [17:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_ctl
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    host.write_reg(a, d);
    case (a)
      3'h0: r0 = d;
      3'h1: r1 = d;
      3'h2: r2 = d;
      3'h5: r5 = d;
      default: ;
    endcase
    repeat (12) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk_ctl(got, exp_out());
  endtask : wr
  task automatic rd(input logic [15:0] e);
    logic [15:0] d;
    logic rel;
    host.read_reg(d, rel);
    chk_word(d, e);
    chk_word({15'h0, rel}, 16'h0001);
  endtask : rd
  task automatic mode(input logic t);
    @(posedge core_clk_i);
    tx_mode_i <= t;
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk_ctl(got, exp_out());
  endtask : mode
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic shadow_reset();
    r0 = RST_POWER_DOWN_CONTROL;
    r1 = RST_RECEIVE_FILTER_CONTROL;
    r2 = RST_GAIN_AND_TUNE_CONTROL;
    r5 = RST_DRIVER_AND_FILTER_CTRL;
  endtask : shadow_reset
  // ****************************************************************
  // clock, watchdog, tests
  // ****************************************************************
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // about twenty write frames of 700 ns each and six shorter reads, with ample margin
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    reset_i = 1'b1;
    tx_mode_i = 1'b0;
    db_tab = '{4'h3, 4'h2, 4'h1, 4'h0, 4'hf, 4'he, 4'hd, 4'ha};
    shadow_reset();
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    chk_ctl(got, exp_out());
    wr(3'h0, 16'h0007);
    rd(16'h0007);
    mode(1'b1);
    mode(1'b0);
    wr(3'h0, 16'h0008);
    wr(3'h0, 16'h0000);
    mode(1'b1);
    mode(1'b0);
    wr(3'h1, 16'h8008);
    rd(16'h8008);
    for (int c = 0; c < 8; c++) wr(3'h2, 16'h7000 | (16'(c) << 2));
    wr(3'h2, 16'h781c);
    rd(16'h781c);
    wr(3'h5, 16'hc812);
    wr(3'h5, 16'h8806);
    wr(3'h5, 16'h8810);
    wr(3'h3, 16'h7ace);
    rd(16'h7ace);
    wr(3'h4, 16'h0000);
    rd(16'h0000);
    wr(3'h6, 16'hffff);
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    shadow_reset();
    repeat (3) @(posedge core_clk_i);
    chk_ctl(got, exp_out());
    wr(3'h0, 16'h0002);
    rd(16'h0002);
    report_and_stop();
  end
endmodule : afe_control_register_bank_test
`default_nettype wire
